// [src/timer_pkg.sv]
// Package of register map, field positions and reset values for the timer block
package timer_pkg;
    localparam logic [7:0] ADDR_MODE_CONTROL    = 8'h00;
    localparam logic [7:0] ADDR_IRQ_SETUP       = 8'h04;
    localparam logic [7:0] ADDR_COUNTER         = 8'h08;
    localparam logic [7:0] ADDR_CAPTURE_RELOAD  = 8'h0C;
    localparam logic [7:0] ADDR_VECTOR          = 8'h10;
    localparam int BIT_OVERFLOW_FLAG            = 7;
    localparam int BIT_EXTERNAL_EVENT_FLAG      = 6;
    localparam int BIT_UART_RX_CLOCK_SELECT     = 5;
    localparam int BIT_UART_TX_CLOCK_SELECT     = 4;
    localparam int BIT_EXTERNAL_TRIGGER_ENABLE  = 3;
    localparam int BIT_RUN_CONTROL              = 2;
    localparam int BIT_COUNTER_OR_TIMER_SELECT  = 1;
    localparam int BIT_CAPTURE_OR_RELOAD_SELECT = 0;
    localparam int BIT_VECTORED_MODE_SELECT     = 5;
    localparam int BIT_REQUEST_PENDING          = 3;
    localparam int BIT_PRIORITY_LSB             = 0;
    localparam logic [7:0]  RESET_MODE_CONTROL   = 8'h00;
    localparam logic [2:0]  RESET_PRIORITY       = 3'h0;
    localparam logic [7:0]  RESET_VECTOR         = 8'h0F;
    localparam logic [15:0] RESET_COUNTER        = 16'h0000;
    localparam logic [15:0] RESET_CAPTURE_RELOAD = 16'h0000;
    localparam logic [15:0] COUNTER_ALL_ONES     = 16'hFFFF;
    localparam logic [1:0]  HTRANS_NONSEQ        = 2'h2;
    localparam logic [2:0]  HSIZE_WORD           = 3'h2;
    localparam int UART_DIVIDE                   = 16;
endpackage : timer_pkg

// [src/timer_mode_and_irq_control.sv]
// Timer/counter with mode control, UART clock select and interrupt request, AHB-Lite slave
`timescale 1ns/1ps
module timer_mode_and_irq_control (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        internal_tick,
    input  wire logic        external_timer_input,
    input  wire logic        irq_acknowledge,
    output logic             irq_request,
    output logic      [2:0]  irq_level,
    output logic             irq_vectored,
    output logic      [7:0]  irq_vector,
    output logic             uart_rx_tick,
    output logic             uart_tx_tick,
    output logic             overflow_pulse
);
    import timer_pkg::*;

    // Bus address phase capture
    logic        wr_pend_q;
    logic [7:0]  wr_addr_q;
    logic [31:0] rdata_q;

    // Register state
    logic        overflow_flag_q;
    logic        external_event_flag_q;
    logic        uart_rx_clock_select_q;
    logic        uart_tx_clock_select_q;
    logic        external_trigger_enable_q;
    logic        run_control_q;
    logic        counter_or_timer_select_q;
    logic        capture_or_reload_select_q;
    logic        vectored_mode_select_q;
    logic        request_pending_q;
    logic [2:0]  priority_q;
    logic [7:0]  vector_number_q;
    logic [15:0] counter_q;
    logic [15:0] capture_reload_q;

    // Synchronisers for pin inputs; stage one is read only by stage two
    logic [2:0]  ext_sync_q;
    logic [2:0]  tick_sync_q;
    logic        ext_level_q;
    logic        tick_level_q;

    // Output flops
    logic        irq_request_q;
    logic        uart_rx_tick_q;
    logic        uart_tx_tick_q;
    logic        overflow_pulse_q;
    logic        hreadyout_q;
    logic        hresp_q;

    // Bus decode
    wire         access_phase = hsel & hready & htrans[1];
    wire         rd_access    = access_phase & ~hwrite;
    wire         wr_access    = access_phase & hwrite;
    wire         wr_mode      = wr_pend_q & (wr_addr_q == ADDR_MODE_CONTROL);
    wire         wr_irq       = wr_pend_q & (wr_addr_q == ADDR_IRQ_SETUP);
    wire         wr_counter   = wr_pend_q & (wr_addr_q == ADDR_COUNTER);
    wire         wr_reload    = wr_pend_q & (wr_addr_q == ADDR_CAPTURE_RELOAD);
    wire         wr_vector    = wr_pend_q & (wr_addr_q == ADDR_VECTOR);

    // Input edge detection, counted once stages two and three agree
    wire         ext_settled  = (ext_sync_q[1] == ext_sync_q[2]);
    wire         tick_settled = (tick_sync_q[1] == tick_sync_q[2]);
    wire         ext_fall     = ext_settled & ~ext_sync_q[2] & ext_level_q;
    wire         tick_rise    = tick_settled & tick_sync_q[2] & ~tick_level_q;

    wire         baud_mode    = uart_rx_clock_select_q | uart_tx_clock_select_q;
    wire         ext_valid    = ext_fall & external_trigger_enable_q & ~baud_mode;
    wire         count_step   = counter_or_timer_select_q ? ext_fall : tick_rise;
    wire         counting     = run_control_q & count_step;
    wire         overflow     = counting & (counter_q == COUNTER_ALL_ONES);
    wire         capture_mode = capture_or_reload_select_q & ~baud_mode;
    wire         do_capture   = ext_valid & capture_mode;
    wire         do_reload    = (overflow & ~capture_mode) | (ext_valid & ~capture_mode);
    wire         set_overflow = overflow & ~baud_mode;
    // Flag on external capture or reload
    wire         set_external = ext_valid;
    wire         valid_request = (set_overflow | set_external) & (priority_q != RESET_PRIORITY);

    wire [15:0]  counter_step = do_reload ? capture_reload_q : counter_q + 16'h0001;
    wire [15:0]  counter_d    = wr_counter ? hwdata[15:0] : (counting | do_reload) ? counter_step : counter_q;
    wire [15:0]  reload_d     = do_capture ? counter_q : wr_reload ? hwdata[15:0] : capture_reload_q;

    // Sticky flag; set wins over software clear
    wire         overflow_flag_d = set_overflow | (wr_mode ? hwdata[BIT_OVERFLOW_FLAG] : overflow_flag_q);
    wire         external_flag_d = set_external | (wr_mode ? hwdata[BIT_EXTERNAL_EVENT_FLAG] : external_event_flag_q);
    // Pending set on a valid request
    wire         pending_raise   = valid_request;
    wire         pending_sw_keep = wr_irq ? hwdata[BIT_REQUEST_PENDING] : 1'b1;
    wire         pending_hold    = request_pending_q & pending_sw_keep & ~irq_acknowledge;
    // Set wins over acknowledge and software clear
    wire         pending_d       = pending_raise | pending_hold;
    // Level after this edge, so a zero write drops the request at once
    wire [2:0]   priority_d      = wr_irq ? hwdata[BIT_PRIORITY_LSB +: 3] : priority_q;
    wire         request_d       = pending_d & (priority_d != RESET_PRIORITY);
    // No tick unless this timer's select bit is set
    wire         rx_tick_d       = overflow & uart_rx_clock_select_q;
    wire         tx_tick_d       = overflow & uart_tx_clock_select_q;

    wire [7:0]   mode_read = {overflow_flag_q, external_event_flag_q, uart_rx_clock_select_q,
                              uart_tx_clock_select_q, external_trigger_enable_q, run_control_q,
                              counter_or_timer_select_q, capture_or_reload_select_q};
    wire [7:0]   irq_read  = {2'h0, vectored_mode_select_q, 1'b0, request_pending_q, priority_q};
    wire [7:0]   rd_offset  = haddr[7:0];
    wire         rd_mode    = (rd_offset == ADDR_MODE_CONTROL);
    wire         rd_irq     = (rd_offset == ADDR_IRQ_SETUP);
    wire         rd_counter = (rd_offset == ADDR_COUNTER);
    wire         rd_reload  = (rd_offset == ADDR_CAPTURE_RELOAD);
    wire         rd_vector  = (rd_offset == ADDR_VECTOR);
    wire [31:0]  read_mux   = rd_mode    ? {24'h000000, mode_read} :
                              rd_irq     ? {24'h000000, irq_read} :
                              rd_counter ? {16'h0000, counter_q} :
                              rd_reload  ? {16'h0000, capture_reload_q} :
                              rd_vector  ? {24'h000000, vector_number_q} :
                                           32'h00000000;

    // Data phase registers; read data stands for one cycle only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_access;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_addr_q <= 8'h00;
        end else begin
            wr_addr_q <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rd_access ? read_mux : 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_sync_q <= 3'h7;
        end else begin
            ext_sync_q <= {ext_sync_q[1:0], external_timer_input};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_sync_q <= 3'h0;
        end else begin
            tick_sync_q <= {tick_sync_q[1:0], internal_tick};
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ext_level_q <= 1'b1;
        end else begin
            ext_level_q <= ext_settled ? ext_sync_q[2] : ext_level_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_level_q <= 1'b0;
        end else begin
            tick_level_q <= tick_settled ? tick_sync_q[2] : tick_level_q;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_flag_q <= RESET_MODE_CONTROL[BIT_OVERFLOW_FLAG];
        end else begin
            overflow_flag_q <= overflow_flag_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            external_event_flag_q <= RESET_MODE_CONTROL[BIT_EXTERNAL_EVENT_FLAG];
        end else begin
            external_event_flag_q <= external_flag_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uart_rx_clock_select_q <= RESET_MODE_CONTROL[BIT_UART_RX_CLOCK_SELECT];
        end else if (wr_mode) begin
            uart_rx_clock_select_q <= hwdata[BIT_UART_RX_CLOCK_SELECT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uart_tx_clock_select_q <= RESET_MODE_CONTROL[BIT_UART_TX_CLOCK_SELECT];
        end else if (wr_mode) begin
            uart_tx_clock_select_q <= hwdata[BIT_UART_TX_CLOCK_SELECT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            external_trigger_enable_q <= RESET_MODE_CONTROL[BIT_EXTERNAL_TRIGGER_ENABLE];
        end else if (wr_mode) begin
            external_trigger_enable_q <= hwdata[BIT_EXTERNAL_TRIGGER_ENABLE];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_control_q <= RESET_MODE_CONTROL[BIT_RUN_CONTROL];
        end else if (wr_mode) begin
            run_control_q <= hwdata[BIT_RUN_CONTROL];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_or_timer_select_q <= RESET_MODE_CONTROL[BIT_COUNTER_OR_TIMER_SELECT];
        end else if (wr_mode) begin
            counter_or_timer_select_q <= hwdata[BIT_COUNTER_OR_TIMER_SELECT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_or_reload_select_q <= RESET_MODE_CONTROL[BIT_CAPTURE_OR_RELOAD_SELECT];
        end else if (wr_mode) begin
            capture_or_reload_select_q <= hwdata[BIT_CAPTURE_OR_RELOAD_SELECT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vectored_mode_select_q <= 1'b0;
        end else if (wr_irq) begin
            vectored_mode_select_q <= hwdata[BIT_VECTORED_MODE_SELECT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            request_pending_q <= 1'b0;
        end else begin
            request_pending_q <= pending_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            priority_q <= RESET_PRIORITY;
        end else begin
            priority_q <= priority_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            vector_number_q <= RESET_VECTOR;
        end else if (wr_vector) begin
            vector_number_q <= hwdata[7:0];
        end
    end

    // Software write to the counter takes priority over a count in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            counter_q <= RESET_COUNTER;
        end else begin
            counter_q <= counter_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            capture_reload_q <= RESET_CAPTURE_RELOAD;
        end else begin
            capture_reload_q <= reload_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_request_q <= 1'b0;
        end else begin
            irq_request_q <= request_d;
        end
    end

    // UART ticks are one-cycle pulses; the UART divides by 16 itself
    // Receive clock routing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uart_rx_tick_q <= 1'b0;
        end else begin
            uart_rx_tick_q <= rx_tick_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            uart_tx_tick_q <= 1'b0;
        end else begin
            uart_tx_tick_q <= tx_tick_d;
        end
    end

    // One pulse per overflow; the reload value sets the baud rate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_pulse_q <= 1'b0;
        end else begin
            overflow_pulse_q <= overflow;
        end
    end

    // Zero wait states and OKAY only; flops keep every output on a register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout_q <= 1'b1;
        end else begin
            hreadyout_q <= 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hresp_q <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
        end
    end

    assign hrdata         = rdata_q;
    assign hreadyout      = hreadyout_q;
    assign hresp          = hresp_q;
    assign irq_request    = irq_request_q;
    assign irq_level      = priority_q;
    assign irq_vectored   = vectored_mode_select_q;
    assign irq_vector     = vector_number_q;
    assign uart_rx_tick   = uart_rx_tick_q;
    assign uart_tx_tick   = uart_tx_tick_q;
    assign overflow_pulse = overflow_pulse_q;
endmodule : timer_mode_and_irq_control

// [verification/timer_mode_and_irq_control_properties.sv]
// Port-level timing checks for the timer block
`timescale 1ns/1ps
module timer_ports_checker (
    input wire logic       hclk,
    input wire logic       hresetn,
    input wire logic       irq_acknowledge,
    input wire logic       irq_request,
    input wire logic [2:0] irq_level,
    input wire logic       irq_vectored,
    input wire logic [7:0] irq_vector,
    input wire logic       uart_rx_tick,
    input wire logic       uart_tx_tick,
    input wire logic       overflow_pulse
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    rx_tick_source_a: assert property (uart_rx_tick |-> overflow_pulse)
        else $error("receive tick without overflow");
    tx_tick_source_a: assert property (uart_tx_tick |-> overflow_pulse)
        else $error("transmit tick without overflow");
    request_needs_level_a: assert property (irq_request |-> irq_level != 3'h0)
        else $error("request at inhibited level");
    single_overflow_a: assert property (overflow_pulse |=> !overflow_pulse)
        else $error("overflow pulse too long");
    ack_clears_a: assert property (irq_acknowledge |-> ##2 !irq_request)
        else $error("request survives acknowledge");
    overflow_request_a: assert property (overflow_pulse && !uart_rx_tick && !uart_tx_tick && irq_level != 3'h0
        |=> irq_request) else $error("overflow raised no request");
    vector_reset_a: assert property ($rose(hresetn) |-> irq_vector == 8'h0F)
        else $error("vector reset value wrong");
    irq_reset_a: assert property ($rose(hresetn) |-> irq_level == 3'h0 && !irq_vectored && !irq_request)
        else $error("interrupt outputs not idle after reset");
endmodule : timer_ports_checker
bind timer_mode_and_irq_control timer_ports_checker chk (.hclk(hclk), .hresetn(hresetn),
    .irq_acknowledge(irq_acknowledge), .irq_request(irq_request), .irq_level(irq_level),
    .irq_vectored(irq_vectored), .irq_vector(irq_vector), .uart_rx_tick(uart_rx_tick),
    .uart_tx_tick(uart_tx_tick), .overflow_pulse(overflow_pulse));

// [verification/cpu_irq_partner.sv]
// Model of the CPU acknowledge logic and the UART baud clock sink
`timescale 1ns/1ps
module cpu_irq_partner (
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       ack_enable,
    input  wire logic [3:0] ack_delay,
    input  wire logic       irq_request,
    input  wire logic       irq_vectored,
    input  wire logic [7:0] irq_vector,
    input  wire logic       uart_rx_tick,
    input  wire logic       uart_tx_tick,
    output logic            irq_acknowledge,
    output logic      [7:0] taken_vector,
    output int              n_rx_ticks,
    output int              n_tx_ticks
);
    logic [3:0] wait_q;
    logic [1:0] hold_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_acknowledge <= 1'b0;
            taken_vector <= 8'h00;
            n_rx_ticks <= 0;
            n_tx_ticks <= 0;
            wait_q <= 4'h0;
            hold_q <= 2'h0;
        end else begin
            irq_acknowledge <= 1'b0;
            n_rx_ticks <= n_rx_ticks + int'(uart_rx_tick);
            n_tx_ticks <= n_tx_ticks + int'(uart_tx_tick);
            // Hold-off covers three cycles, more than the one the request needs to drop
            if (hold_q != 2'h0) begin
                hold_q <= hold_q - 2'h1;
            end else if (ack_enable && irq_request) begin
                wait_q <= wait_q + 4'h1;
                if (wait_q >= ack_delay) begin
                    // acknowledge takes vector only when vectored
                    irq_acknowledge <= 1'b1;
                    taken_vector <= irq_vectored ? irq_vector : 8'h00;
                    wait_q <= 4'h0;
                    hold_q <= 2'h3;
                end
            end else begin
                wait_q <= 4'h0;
            end
        end
    end
endmodule : cpu_irq_partner

// [verification/timer_mode_and_irq_control_tb.sv]
// Self-checking bench for the timer block
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %0t got %h want %h", $time, g, e); end end
module timer_mode_and_irq_control_tb;
    import timer_pkg::*;
    logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0, ext = 1'b1, ack_en = 1'b1;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = HSIZE_WORD, irq_level;
    logic [3:0]  dly = 4'h0;
    logic [7:0]  irq_vector, taken_vector;
    logic        hreadyout, irq_acknowledge, irq_request, irq_vectored, rx_t, tx_t;
    int          n_errors = 0, samples_checked = 0, n_rx, n_tx;
    initial forever #2 hclk = ~hclk;
    timer_mode_and_irq_control uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(), .internal_tick(tick), .external_timer_input(ext), .irq_acknowledge(irq_acknowledge),
        .irq_request(irq_request), .irq_level(irq_level), .irq_vectored(irq_vectored), .irq_vector(irq_vector),
        .uart_rx_tick(rx_t), .uart_tx_tick(tx_t), .overflow_pulse());
    cpu_irq_partner cpu (.hclk(hclk), .hresetn(hresetn), .ack_enable(ack_en), .ack_delay(dly),
        .irq_request(irq_request), .irq_vectored(irq_vectored), .irq_vector(irq_vector), .uart_rx_tick(rx_t),
        .uart_tx_tick(tx_t), .irq_acknowledge(irq_acknowledge), .taken_vector(taken_vector),
        .n_rx_ticks(n_rx), .n_tx_ticks(n_tx));
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    task automatic wait_rdy;
        for (int i = 0; i < 20; i++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) return;
        end
        n_errors++;
        tally_and_finish();
    endtask : wait_rdy
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
        rd = hrdata;
    endtask : xfer
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask : rchk
    task automatic pulse(input int n, input logic on_ext);
        repeat (n) begin
            if (on_ext) ext <= 1'b0;
            else tick <= 1'b1;
            repeat (3) @(posedge hclk);
            ext <= 1'b1;
            tick <= 1'b0;
            repeat (3) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask : pulse
    task automatic wait_idle;
        for (int i = 0; i < 60 && irq_request !== 1'b0; i++) @(posedge hclk);
        `CHK(irq_request, 1'b0)
        if (irq_request !== 1'b0) tally_and_finish();
    endtask : wait_idle
    task automatic t_reset;
        rchk(ADDR_MODE_CONTROL, 32'h0);
        rchk(ADDR_IRQ_SETUP, 32'h0);
        rchk(ADDR_VECTOR, 32'h0F);
        rchk(8'h14, 32'h0);
    endtask : t_reset
    task automatic t_count;
        xfer(1'b1, ADDR_COUNTER, 32'h10);
        pulse(3, 1'b0);
        rchk(ADDR_COUNTER, 32'h10);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h04);
        pulse(3, 1'b0);
        rchk(ADDR_COUNTER, 32'h13);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h06);
        pulse(2, 1'b1);
        pulse(2, 1'b0);
        rchk(ADDR_COUNTER, 32'h15);
    endtask : t_count
    task automatic t_irq;
        xfer(1'b1, ADDR_IRQ_SETUP, 32'h25);
        xfer(1'b1, ADDR_CAPTURE_RELOAD, 32'h1234);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h04);
        xfer(1'b1, ADDR_COUNTER, 32'hFFFF);
        pulse(1, 1'b0);
        rchk(ADDR_COUNTER, 32'h1234);
        rchk(ADDR_MODE_CONTROL, 32'h84);
        wait_idle();
        `CHK(taken_vector, 8'h0F)
        rchk(ADDR_IRQ_SETUP, 32'h25);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h04);
        rchk(ADDR_MODE_CONTROL, 32'h04);
    endtask : t_irq
    task automatic t_swclear;
        ack_en <= 1'b0;
        xfer(1'b1, ADDR_IRQ_SETUP, 32'h00);
        xfer(1'b1, ADDR_COUNTER, 32'hFFFF);
        pulse(1, 1'b0);
        rchk(ADDR_IRQ_SETUP, 32'h00);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h04);
        xfer(1'b1, ADDR_IRQ_SETUP, 32'h03);
        xfer(1'b1, ADDR_COUNTER, 32'hFFFF);
        pulse(1, 1'b0);
        rchk(ADDR_IRQ_SETUP, 32'h0B);
        xfer(1'b1, ADDR_IRQ_SETUP, 32'h03);
        rchk(ADDR_IRQ_SETUP, 32'h03);
        `CHK(irq_request, 1'b0)
        dly <= 4'h6;
        ack_en <= 1'b1;
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h04);
        xfer(1'b1, ADDR_COUNTER, 32'hFFFF);
        pulse(1, 1'b0);
        wait_idle();
        `CHK(taken_vector, 8'h00)
    endtask : t_swclear
    task automatic t_capture;
        xfer(1'b1, ADDR_CAPTURE_RELOAD, 32'h0);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h05);
        xfer(1'b1, ADDR_COUNTER, 32'h0100);
        pulse(1, 1'b1);
        rchk(ADDR_CAPTURE_RELOAD, 32'h0);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h0D);
        pulse(2, 1'b0);
        pulse(1, 1'b1);
        rchk(ADDR_CAPTURE_RELOAD, 32'h0102);
        rchk(ADDR_MODE_CONTROL, 32'h4D);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h0C);
        xfer(1'b1, ADDR_COUNTER, 32'h0);
        pulse(1, 1'b1);
        rchk(ADDR_COUNTER, 32'h0102);
    endtask : t_capture
    task automatic t_baud;
        xfer(1'b1, ADDR_CAPTURE_RELOAD, 32'hFFFE);
        xfer(1'b1, ADDR_COUNTER, 32'hFFFE);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h25);
        pulse(4, 1'b0);
        `CHK(n_rx, 2)
        rchk(ADDR_MODE_CONTROL, 32'h25);
        rchk(ADDR_COUNTER, 32'hFFFE);
        xfer(1'b1, ADDR_MODE_CONTROL, 32'h1D);
        pulse(1, 1'b1);
        rchk(ADDR_COUNTER, 32'hFFFE);
        pulse(2, 1'b0);
        `CHK(n_tx, 1)
        `CHK(n_rx, 2)
    endtask : t_baud
    initial begin
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_count();
        t_irq();
        t_swclear();
        t_capture();
        t_baud();
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        tally_and_finish();
    end
endmodule : timer_mode_and_irq_control_tb
